// ---- design/psm_defines.svh ----
/*
 * Constants for the supply monitor flag logic: register address, bit
 * positions, reset value, trip codes and timing counts.
 * Assumes a 50 MHz core clock and an 8-bit special-function-register bus.
 */
// Summary of operation
// (R01) Monitor works only while enable bit 0 is 1; writing 0 disables it.
// (R02) Bits 4:3 pick digital trip: 00 4.63, 01 3.08, 10 2.93, 11 2.63 V.
// (R03) Bits 2:1 pick analog trip with the same code mapping.
// (R04) Bit 7 reads the live digital comparator, 1 above threshold.
// (R05) Bit 6 reads the live analog comparator, 1 above threshold.
// (R06) Low-supply flag sets whenever either comparator output is low.
// (R07) Both comparators high and staying high start 250 ms; expiry clears flag.
// (R08) Software may write the flag but cannot clear it while a supply is low.
// (R09) Flag raises an interrupt only when its external enable bit is set.
// (R10) Brief glitches on comparator outputs are filtered out.
// (R11) Control/status register reads 0xde after power-on.
// (R12) A comparator falling low during the hold-off restarts it; flag stays set.
// (R13) Both comparator outputs pass two flip-flops before any use.
`ifndef PSM_DEFINES_SVH
`define PSM_DEFINES_SVH

`define PSM_CTRL_ADDR 8'hdf
`define PSM_CTRL_RESET 8'hde

`define PSM_BIT_ENABLE 0
`define PSM_BIT_ANA_LO 1
`define PSM_BIT_ANA_HI 2
`define PSM_BIT_DIG_LO 3
`define PSM_BIT_DIG_HI 4
`define PSM_BIT_FLAG 5
`define PSM_BIT_ANA_CMP 6
`define PSM_BIT_DIG_CMP 7

`define PSM_TRIP_4V63 2'h0
`define PSM_TRIP_3V08 2'h1
`define PSM_TRIP_2V93 2'h2
`define PSM_TRIP_2V63 2'h3

`define PSM_CLK_HZ 50000000
`define PSM_HOLD_MS 250
`define PSM_MS_CYCLES (`PSM_CLK_HZ / 1000)
`define PSM_GLITCH_CYCLES 16

`endif

// ---- design/psm_pkg.sv ----
/*
 * Types shared by the supply monitor flag logic.
 * Assumes psm_defines.svh supplies the numeric constants.
 */
package psm_pkg;

	typedef logic [1:0] psm_trip_type;

	typedef enum logic [1:0]
	{
		PSM_IDLE = 2'b00,
		PSM_LOW = 2'b01,
		PSM_HOLD = 2'b10
	} psm_state_type;

endpackage : psm_pkg

// ---- design/psm_cmp_filter.sv ----
/*
 * Synchroniser and glitch filter for one comparator output.
 * Assumes the comparator output is asynchronous and idles high.
 */
`timescale 1ns/1ps
`include "psm_defines.svh"

module psm_cmp_filter
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic cmp_raw,
	output logic cmp_sync,
	output logic cmp_filt
);

	import psm_pkg::*;

	logic meta_reg;
	logic sync_reg;
	logic filt_reg;
	logic [4:0] cnt_reg;
	logic [4:0] cnt_next;
	wire differs;
	wire settled;

	assign differs = sync_reg != filt_reg;
	assign settled = cnt_reg == 5'(`PSM_GLITCH_CYCLES - 1);
	assign cnt_next = differs ? cnt_reg + 5'h01 : 5'h00;

	// Two stages before any use
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_reg <= 1'b1;
			sync_reg <= 1'b1;
		end
		else
		begin
			meta_reg <= cmp_raw; // R13
			sync_reg <= meta_reg; // R13
		end
	end

	// New level accepted only after it holds for the whole window
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			filt_reg <= 1'b1;
			cnt_reg <= 5'h00;
		end
		else if (differs && settled)
		begin
			filt_reg <= sync_reg; // R10
			cnt_reg <= 5'h00;
		end
		else
			cnt_reg <= cnt_next; // R10
	end

	assign cmp_sync = sync_reg;
	assign cmp_filt = filt_reg;

endmodule : psm_cmp_filter

// ---- design/psm_monitor.sv ----
/*
 * Supply monitor flag logic: control/status register on the SFR bus,
 * comparator conditioning, low-supply flag and 250 ms hold-off timer.
 * Assumes comparators and the interrupt controller sit outside and that
 * SFR bus strobes are one-cycle pulses synchronous to sys_clk.
 */
`timescale 1ns/1ps
`include "psm_defines.svh"

module psm_monitor
#(
	parameter int unsigned MS_CYCLES = `PSM_MS_CYCLES,
	parameter int unsigned HOLD_MS = `PSM_HOLD_MS
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	output logic sfr_hit,
	input wire logic digital_supply_compare,
	input wire logic analog_supply_compare,
	output logic monitor_enable,
	output psm_pkg::psm_trip_type digital_threshold,
	output psm_pkg::psm_trip_type analog_threshold,
	input wire logic interrupt_enable_priority_two,
	output logic low_supply_flag,
	output logic low_supply_irq
);

	import psm_pkg::*;

	logic [4:0] ctrl_reg;
	logic [4:0] ctrl_next;
	logic flag_reg;
	logic flag_next;
	logic [7:0] rdata_reg;
	psm_state_type state_reg;
	psm_state_type state_next;
	logic [15:0] div_reg;
	logic [15:0] div_next;
	logic [7:0] hold_reg;
	logic [7:0] hold_next;
	logic [7:0] rdata_next;
	logic [1:0] cmp_raw;
	logic [1:0] cmp_sync;
	logic [1:0] cmp_filt;

	wire reg_sel;
	wire reg_wr;
	wire reg_rd;
	wire enabled;
	wire supply_low;
	wire supply_ok;
	wire in_hold;
	wire ms_end;
	wire hold_end;
	wire ms_tick;
	wire hold_done;
	wire hold_clear;
	wire sw_flag;
	wire clear_blocked;
	wire sw_write;
	wire [7:0] status_word;

	// Register address match
	function automatic logic addr_match(input logic [7:0] addr);
		addr_match = addr == `PSM_CTRL_ADDR;
	endfunction : addr_match

	assign cmp_raw[0] = analog_supply_compare;
	assign cmp_raw[1] = digital_supply_compare;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1)
		begin : g_cmp
			psm_cmp_filter u_filter
			(
				.sys_clk(sys_clk),
				.rst_n(rst_n),
				.cmp_raw(cmp_raw[gi]),
				.cmp_sync(cmp_sync[gi]),
				.cmp_filt(cmp_filt[gi])
			);
		end
	endgenerate

	// Bus decode
	assign reg_sel = addr_match(sfr_addr);
	assign reg_wr = sfr_wr && reg_sel;
	assign reg_rd = sfr_rd && reg_sel;
	assign sfr_hit = reg_sel && (sfr_wr || sfr_rd);

	// Control field writes
	assign ctrl_next = reg_wr ? sfr_wdata[4:0] : ctrl_reg;
	assign enabled = ctrl_reg[`PSM_BIT_ENABLE]; // R01

	// Low condition from filtered comparators
	assign supply_ok = cmp_filt[0] && cmp_filt[1];
	assign supply_low = enabled && !supply_ok; // R06 R01

	// Millisecond time base, restarted on entry to hold-off
	assign in_hold = state_reg == PSM_HOLD;
	assign ms_end = div_reg == 16'(MS_CYCLES - 1);
	assign hold_end = hold_reg == 8'(HOLD_MS - 1);
	assign ms_tick = in_hold && ms_end;
	assign hold_done = ms_tick && hold_end; // R07

	// A clear is refused while a comparator reads low, glitch or not
	assign sw_flag = sfr_wdata[`PSM_BIT_FLAG];
	assign clear_blocked = enabled && !(cmp_sync[0] && cmp_sync[1]); // R08
	assign sw_write = reg_wr && (sw_flag || !clear_blocked); // R08

	// Flag: hardware set wins over any software write
	always_comb
	begin
		flag_next = flag_reg;
		if (supply_low)
			flag_next = 1'b1; // R06 R08
		else if (sw_write)
			flag_next = sw_flag; // R08
		else if (hold_done)
			flag_next = 1'b0; // R07
	end

	// Hold-off sequencing
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			PSM_IDLE:
				if (supply_low)
					state_next = PSM_LOW;
			PSM_LOW:
				if (!supply_low)
					state_next = PSM_HOLD; // R07
			PSM_HOLD:
				if (supply_low)
					state_next = PSM_LOW; // R12
				else if (hold_done)
					state_next = PSM_IDLE; // R07
			default:
				state_next = PSM_IDLE;
		endcase
	end

	// Read word: live comparators, flag and control fields
	assign status_word =
	{
		cmp_sync[1], // R04 R13
		cmp_sync[0], // R05 R13
		flag_reg,
		ctrl_reg
	};

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_reg <= 5'(`PSM_CTRL_RESET & 8'h1f); // R11
			flag_reg <= 1'b0; // R11
		end
		else
		begin
			ctrl_reg <= ctrl_next; // R01 R02 R03
			flag_reg <= flag_next;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			state_reg <= PSM_IDLE;
		else
			state_reg <= state_next;
	end

	// Hold-off counters run only in the hold state, restart on any low
	assign hold_clear = !in_hold || supply_low; // R12
	assign div_next = (hold_clear || ms_tick) ? 16'h0000
		: div_reg + 16'h0001; // R07
	assign hold_next = hold_clear ? 8'h00
		: (ms_tick ? hold_reg + 8'h01 : hold_reg); // R07 R12

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_reg <= 16'h0000;
			hold_reg <= 8'h00;
		end
		else
		begin
			div_reg <= div_next;
			hold_reg <= hold_next;
		end
	end

	// Registered read data, zero for other addresses
	assign rdata_next = reg_rd ? status_word : 8'h00;
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_reg <= 8'h00;
		else if (sfr_rd)
			rdata_reg <= rdata_next;
	end

	assign sfr_rdata = rdata_reg;
	assign monitor_enable = ctrl_reg[`PSM_BIT_ENABLE]; // R01
	assign digital_threshold =
		ctrl_reg[`PSM_BIT_DIG_HI:`PSM_BIT_DIG_LO]; // R02
	assign analog_threshold =
		ctrl_reg[`PSM_BIT_ANA_HI:`PSM_BIT_ANA_LO]; // R03
	assign low_supply_flag = flag_reg;
	assign low_supply_irq = flag_reg && interrupt_enable_priority_two; // R09

endmodule : psm_monitor

// ---- testbench/psm_monitor_checker.sv ----
/* Assertions on the supply monitor ports.
   Assumes the bench keeps supplies good during reset. */
`timescale 1ns/1ps
module psm_monitor_checker
#(
	parameter int unsigned MS_CYCLES = 4,
	parameter int unsigned HOLD_MS = 3
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic sfr_hit,
	input wire logic digital_supply_compare,
	input wire logic analog_supply_compare,
	input wire logic monitor_enable,
	input wire psm_pkg::psm_trip_type digital_threshold,
	input wire psm_pkg::psm_trip_type analog_threshold,
	input wire logic interrupt_enable_priority_two,
	input wire logic low_supply_flag,
	input wire logic low_supply_irq
);
	import psm_pkg::*;
	localparam int unsigned HOLD_END = MS_CYCLES * HOLD_MS + 28;
	logic [7:0] low_cnt;
	logic [7:0] high_cnt;
	logic armed;
	wire wr_hit = sfr_wr && sfr_addr == 8'hdf;
	wire rd_hit = sfr_rd && sfr_addr == 8'hdf;
	wire low = !digital_supply_compare || !analog_supply_compare;
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			low_cnt <= 8'h00;
			high_cnt <= 8'h00;
			armed <= 1'b0;
		end
		else
		begin
			low_cnt <= (low && monitor_enable && $stable(low)) ?
				low_cnt + {7'h00, low_cnt != 8'hff} : 8'h00;
			high_cnt <= (!low && monitor_enable && !wr_hit) ?
				high_cnt + {7'h00, high_cnt != 8'hff} : 8'h00;
			armed <= !wr_hit && (armed || low_cnt == 8'h16);
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	AST_ENABLE: assert property (wr_hit
		|=> monitor_enable == $past(sfr_wdata[0]))
		else $error("enable bit not taken");
	AST_DIG_TRIP: assert property (wr_hit
		|=> digital_threshold == $past(sfr_wdata[4:3]))
		else $error("digital trip not taken");
	AST_ANA_TRIP: assert property (wr_hit
		|=> analog_threshold == $past(sfr_wdata[2:1]))
		else $error("analog trip not taken");
	AST_DIG_STAT: assert property (rd_hit
		|=> sfr_rdata[7] == $past(digital_supply_compare, 3))
		else $error("digital status wrong");
	AST_ANA_STAT: assert property (rd_hit
		|=> sfr_rdata[6] == $past(analog_supply_compare, 3))
		else $error("analog status wrong");
	AST_FLAG_SET: assert property (low_cnt == 8'h18
		|-> low_supply_flag)
		else $error("flag not set on low supply");
	AST_NO_CLEAR: assert property (low_cnt > 8'h14 && wr_hit
		|=> low_supply_flag)
		else $error("flag cleared while low");
	AST_IRQ: assert property (low_supply_irq
		== (low_supply_flag && interrupt_enable_priority_two))
		else $error("irq not flag and enable");
	AST_HOLD: assert property (armed && high_cnt == HOLD_END
		|-> !low_supply_flag)
		else $error("flag not cleared after hold");
	AST_HIT: assert property (sfr_hit
		== (wr_hit || rd_hit))
		else $error("register hit wrong");
	cover property (low_cnt == 8'h18);
	cover property (armed && $fell(low_supply_flag));
	cover property (low_supply_irq);
endmodule : psm_monitor_checker

bind psm_monitor psm_monitor_checker #(.MS_CYCLES(MS_CYCLES),
	.HOLD_MS(HOLD_MS)) u_psm_monitor_checker (.sys_clk, .rst_n,
	.sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .sfr_hit,
	.digital_supply_compare, .analog_supply_compare, .monitor_enable,
	.digital_threshold, .analog_threshold, .interrupt_enable_priority_two,
	.low_supply_flag, .low_supply_irq);

// ---- testbench/psm_supply_model.sv ----
/* Model of the two supply comparators, answering a little late.
   Assumes the bench says which supply is good. */
`timescale 1ns/1ps
module psm_supply_model
(
	input wire logic dig_ok,
	input wire logic ana_ok,
	output logic digital_supply_compare,
	output logic analog_supply_compare
);
	assign #3 digital_supply_compare = dig_ok;
	assign #7 analog_supply_compare = ana_ok;
endmodule : psm_supply_model

// ---- testbench/psm_monitor_bench.sv ----
/* Bench for psm_monitor: register, flag, glitch and hold-off.
   Assumes the comparator model and the bound checker. */
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
$display("wrong value at %0t: %h not %h", $time, a, b); end end
module psm_monitor_bench;
	import psm_pkg::*;
	logic sys_clk = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 0;
	logic dig_ok = 1, ana_ok = 1, interrupt_enable_priority_two = 0;
	logic [7:0] sfr_addr = 8'hdf, sfr_wdata = 8'h00, sfr_rdata;
	logic sfr_hit, digital_supply_compare, analog_supply_compare;
	logic monitor_enable, low_supply_flag, low_supply_irq;
	psm_trip_type digital_threshold, analog_threshold;
	int bad_count = 0, cmp_count = 0;
	always #10 sys_clk = ~sys_clk;
	psm_supply_model u_psm_supply_model (.dig_ok, .ana_ok,
		.digital_supply_compare, .analog_supply_compare);
	psm_monitor #(.MS_CYCLES(4), .HOLD_MS(3)) u_psm_monitor (.sys_clk,
		.rst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
		.sfr_hit, .digital_supply_compare, .analog_supply_compare,
		.monitor_enable, .digital_threshold, .analog_threshold,
		.interrupt_enable_priority_two, .low_supply_flag, .low_supply_irq);
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : cyc
	task automatic wr(input logic [7:0] d);
		sfr_wdata = d;
		sfr_wr = 1;
		cyc(1);
		sfr_wr = 0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		sfr_addr = a;
		sfr_rd = 1;
		cyc(1);
		sfr_rd = 0;
		sfr_addr = 8'hdf;
		cyc(1);
		`CHK(sfr_rdata, e)
	endtask : rd
	task automatic t_reset();
		rd(8'hdf, 8'hde);
		rd(8'h10, 8'h00);
	endtask : t_reset
	task automatic t_fields();
		for (int k = 0; k < 4; k++)
		begin
			wr({3'h0, 2'(k), 2'(3 - k), 1'b1});
			`CHK({digital_threshold, analog_threshold}, {2'(k), 2'(3 - k)})
			rd(8'hdf, {3'h6, 2'(k), 2'(3 - k), 1'b1});
		end
		`CHK(monitor_enable, 1'b1)
	endtask : t_fields
	task automatic t_flag();
		interrupt_enable_priority_two = 1;
		dig_ok = 0;
		cyc(6);
		dig_ok = 1;
		cyc(30);
		`CHK(low_supply_flag, 1'b0)
		dig_ok = 0;
		cyc(2);
		rd(8'hdf, 8'h59);
		cyc(20);
		`CHK({low_supply_flag, low_supply_irq}, 2'b11)
		wr(8'h07);
		`CHK(low_supply_flag, 1'b1)
		interrupt_enable_priority_two = 0;
		cyc(1);
		`CHK(low_supply_irq, 1'b0)
		dig_ok = 1;
		ana_ok = 0;
		cyc(3);
		rd(8'hdf, 8'ha7);
		ana_ok = 1;
		cyc(2);
		ana_ok = 0;
		cyc(24);
		ana_ok = 1;
		cyc(27);
		`CHK(low_supply_flag, 1'b1)
		cyc(15);
		`CHK(low_supply_flag, 1'b0)
	endtask : t_flag
	task automatic t_off();
		wr(8'h06);
		ana_ok = 0;
		cyc(30);
		`CHK(low_supply_flag, 1'b0)
		ana_ok = 1;
	endtask : t_off
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	initial
	begin
		repeat (5000) @(posedge sys_clk);
		bad_count++;
		wrap_up();
	end
	initial
	begin
		cyc(20);
		rst_n = 1;
		cyc(2);
		t_reset();
		t_fields();
		t_flag();
		t_off();
		wrap_up();
	end
endmodule : psm_monitor_bench
